// ---- src/ddef_flags.sv ----
`timescale 1ns/1ps
module ddef_flags #(
  parameter int DW             = ddef_pkg::DATA_W,
  parameter int CAL_W          = 64,
  parameter int REFRESH_CYCLES = ddef_pkg::REFRESH_CYCLES
) (
  input  wire logic                        clock,
  input  wire logic                        srst,
  input  wire logic                        ce,
  input  wire logic                        spi_sclk,
  input  wire logic                        spi_cs_n,
  input  wire logic                        spi_mosi,
  output logic                             spi_miso,
  input  wire logic                        spi_crc_enable,
  input  wire logic [ddef_pkg::FLAG_W-1:0] digital_fault_enables,
  input  wire logic                        rc_enable,
  input  wire logic                        rc_valid,
  input  wire logic [DW-1:0]               rc_word,
  input  wire logic                        rc_parity,
  input  wire logic [DW-1:0]               latch_in,
  input  wire logic [DW-1:0]               latch_out,
  input  wire logic [DW-1:0]               dac_code,
  input  wire logic [DW-1:0]               dac_code_inv,
  input  wire logic                        cal_refresh_start,
  input  wire logic [CAL_W-1:0]            cal_contents,
  input  wire logic [ddef_pkg::CRC_W-1:0]  cal_stored_crc,
  output logic [ddef_pkg::FLAG_W-1:0]      digital_fault_flags,
  output logic                             cal_refresh_busy,
  output logic                             cal_unrefreshed
);

  localparam int RW = $clog2(REFRESH_CYCLES + 1);

  // ---------------------------------------------------------------------
  // link domain: shift in on falling edges
  // ---------------------------------------------------------------------
  logic                         in_frame;
  logic                         frame_tog;
  logic [ddef_pkg::CNT_W-1:0]   link_cnt;
  logic [ddef_pkg::SHIFT_W-1:0] link_shift;
  logic [ddef_pkg::FRAME_W-1:0] miso_shift;
  logic [ddef_pkg::FRAME_W-1:0] rb_word;

  // cs_n high ends the frame without needing a further sclk edge
  always_ff @(negedge spi_sclk or posedge spi_cs_n or posedge srst) begin
    if (spi_cs_n || srst) begin
      in_frame <= 1'b0;
    end else begin
      in_frame <= 1'b1;
    end
  end

  // count and word stay put after the frame so the core can take them
  always_ff @(negedge spi_sclk or posedge srst) begin
    if (srst) begin
      frame_tog  <= 1'b0;
      link_cnt   <= 6'h00;
      link_shift <= 32'h0000_0000;
    end else if (!in_frame) begin
      frame_tog  <= ~frame_tog;
      link_cnt   <= 6'h01;
      link_shift <= {31'h0000_0000, spi_mosi};
    end else begin
      if (link_cnt != ddef_pkg::COUNT_MAX) begin
        link_cnt <= link_cnt + 6'h01;
      end
      link_shift <= {link_shift[ddef_pkg::SHIFT_W-2:0], spi_mosi};
    end
  end

  // rb_word is only rewritten between frames, so it is quiet here
  always_ff @(negedge spi_sclk or posedge srst) begin
    if (srst) begin
      spi_miso   <= 1'b0;
      miso_shift <= 24'h00_0000;
    end else if (!in_frame) begin
      spi_miso   <= rb_word[ddef_pkg::FRAME_W-1];
      miso_shift <= {rb_word[ddef_pkg::FRAME_W-2:0], 1'b0};
    end else begin
      spi_miso   <= miso_shift[ddef_pkg::FRAME_W-1];
      miso_shift <= {miso_shift[ddef_pkg::FRAME_W-2:0], 1'b0};
    end
  end

  // ---------------------------------------------------------------------
  // crossings into the core clock
  // ---------------------------------------------------------------------
  logic cs_meta;
  logic cs_sync;
  logic cs_prev;
  logic tog_meta;
  logic tog_sync;
  logic tog_seen;
  logic frame_end;
  logic had_edges;

  always_ff @(posedge clock) begin
    if (srst) begin
      cs_meta  <= 1'b1;
      cs_sync  <= 1'b1;
      cs_prev  <= 1'b1;
      tog_meta <= 1'b0;
      tog_sync <= 1'b0;
    end else if (ce) begin
      cs_meta  <= spi_cs_n;
      cs_sync  <= cs_meta;
      cs_prev  <= cs_sync;
      tog_meta <= frame_tog;
      tog_sync <= tog_meta;
    end
  end

  assign frame_end = cs_sync && !cs_prev;
  assign had_edges = tog_sync != tog_seen;

  // ---------------------------------------------------------------------
  // frame capture and crc check
  // ---------------------------------------------------------------------
  ddef_pkg::ddef_state_type     state;
  logic [ddef_pkg::CNT_W-1:0]   cap_cnt;
  logic [ddef_pkg::FRAME_W-1:0] cap_frame;
  logic [ddef_pkg::CRC_W-1:0]   cap_crc;

  ddef_crc_if #(.DW(ddef_pkg::FRAME_W)) spi_crc_bus ();
  ddef_crc_if #(.DW(CAL_W))             cal_crc_bus ();

  ddef_crc #(.DW(ddef_pkg::FRAME_W)) u_spi_crc (
    .clock (clock),
    .srst  (srst),
    .ce    (ce),
    .port  (spi_crc_bus.calc)
  );

  assign spi_crc_bus.start = state == ddef_pkg::ST_START;
  assign spi_crc_bus.data  = cap_frame;

  always_ff @(posedge clock) begin
    if (srst) begin
      state     <= ddef_pkg::ST_IDLE;
      tog_seen  <= 1'b0;
      cap_cnt   <= 6'h00;
      cap_frame <= 24'h00_0000;
      cap_crc   <= 8'h00;
    end else if (ce) begin
      case (state)
        ddef_pkg::ST_IDLE: begin
          if (frame_end) begin
            tog_seen <= tog_sync;
            cap_cnt  <= had_edges ? link_cnt : 6'h00;
            cap_crc  <= link_shift[ddef_pkg::CRC_W-1:0];
            if (link_cnt == ddef_pkg::LONG_COUNT) begin
              cap_frame <= link_shift[ddef_pkg::SHIFT_W-1:ddef_pkg::CRC_W];
            end else begin
              cap_frame <= link_shift[ddef_pkg::FRAME_W-1:0];
            end
            state <= ddef_pkg::ST_START;
          end
        end
        ddef_pkg::ST_START: state <= ddef_pkg::ST_CHECK;
        ddef_pkg::ST_CHECK: begin
          if (spi_crc_bus.done) begin
            state <= ddef_pkg::ST_IDLE;
          end
        end
        default: state <= ddef_pkg::ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // access decode
  // ---------------------------------------------------------------------
  logic                        busy;
  logic                        first_done;
  logic                        decide;
  logic                        cnt_ok;
  logic                        slip_bad;
  logic                        crc_bad;
  logic                        frame_ok;
  logic                        is_write;
  logic [ddef_pkg::ADDR_W-1:0] addr;
  logic                        write_blocked;
  logic                        invalid;
  logic                        accept;
  logic                        clear_write;

  assign decide = state == ddef_pkg::ST_CHECK && spi_crc_bus.done;
  assign cnt_ok = spi_crc_enable ? cap_cnt == ddef_pkg::LONG_COUNT
                : (cap_cnt == ddef_pkg::LONG_COUNT
                   || cap_cnt == ddef_pkg::SHORT_COUNT);
  assign slip_bad = cnt_ok && (cap_frame[ddef_pkg::SLIP_MARK_POS]
                    == cap_frame[ddef_pkg::SLIP_PAIR_POS]);
  assign crc_bad  = cnt_ok && spi_crc_enable
                    && spi_crc_bus.crc != cap_crc;
  assign frame_ok = cnt_ok && !slip_bad && !crc_bad;
  assign is_write = cap_frame[ddef_pkg::WRITE_POS];
  assign addr     = cap_frame[ddef_pkg::ADDR_LSB +: ddef_pkg::ADDR_W];
  // readback select is the one write let through while refreshing
  assign write_blocked = is_write && (busy
                         ? addr != ddef_pkg::READBACK_SELECT_ADDR
                         : !first_done);
  assign invalid = frame_ok && (!ddef_pkg::VALID_ADDR_MAP[addr]
                   || (is_write && ddef_pkg::READ_ONLY_MAP[addr])
                   || write_blocked);
  assign accept      = frame_ok && !invalid;
  assign clear_write = accept && is_write
                       && addr == ddef_pkg::FAULT_FLAGS_ADDR;

  // ---------------------------------------------------------------------
  // calibration memory refresh
  // ---------------------------------------------------------------------
  logic          cal_start;
  logic          cal_bad;
  logic          ref_end;
  logic [RW-1:0] ref_cnt;

  ddef_crc #(.DW(CAL_W)) u_cal_crc (
    .clock (clock),
    .srst  (srst),
    .ce    (ce),
    .port  (cal_crc_bus.calc)
  );

  assign cal_crc_bus.start = cal_start;
  assign cal_crc_bus.data  = cal_contents;
  assign busy              = cal_refresh_busy;
  assign ref_end           = busy && ref_cnt == '0;

  always_ff @(posedge clock) begin
    if (srst) begin
      cal_refresh_busy <= 1'b0;
      cal_unrefreshed  <= 1'b1;
      first_done       <= 1'b0;
      cal_start        <= 1'b0;
      ref_cnt          <= '0;
    end else if (ce) begin
      cal_start <= cal_refresh_start && !busy;
      if (cal_refresh_start && !busy) begin
        cal_refresh_busy <= 1'b1;
        cal_unrefreshed  <= 1'b1;
        ref_cnt          <= RW'(REFRESH_CYCLES - 1);
      end else if (ref_end) begin
        cal_refresh_busy <= 1'b0;
        cal_unrefreshed  <= 1'b0;
        first_done       <= 1'b1;
      end else if (busy) begin
        ref_cnt <= ref_cnt - RW'(1);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      cal_bad <= 1'b0;
    end else if (ce && cal_crc_bus.done) begin
      cal_bad <= cal_crc_bus.crc != cal_stored_crc;
    end
  end

  // ---------------------------------------------------------------------
  // sticky flags, readback word
  // ---------------------------------------------------------------------
  logic [ddef_pkg::FLAG_W-1:0] flags;
  logic [ddef_pkg::FLAG_W-1:0] set_vec;
  logic [ddef_pkg::FLAG_W-1:0] clr_vec;
  logic [ddef_pkg::FLAG_W-1:0] kept;
  logic [ddef_pkg::FLAG_W-1:0] next_flags;
  logic [ddef_pkg::ADDR_W-1:0] rb_sel;
  logic [ddef_pkg::ADDR_W-1:0] next_rb_sel;

  always_comb begin
    set_vec = 10'h000;
    set_vec[ddef_pkg::INTERDIE_READCOMPARE_PARITY_FLAG] = rc_enable
      && rc_valid && ((^rc_word) != rc_parity);
    set_vec[ddef_pkg::LATCH_MONITOR_MISMATCH_FLAG] =
      latch_in != latch_out;
    set_vec[ddef_pkg::INVERTED_CODE_FLAG] =
      dac_code != ~dac_code_inv;
    set_vec[ddef_pkg::CAL_CRC_FLAG]        = ref_end && cal_bad;
    set_vec[ddef_pkg::INVALID_ACCESS_FLAG] = decide && invalid;
    set_vec[ddef_pkg::CLOCK_COUNT_FLAG]    = decide && !cnt_ok;
    set_vec[ddef_pkg::FRAME_SLIP_FLAG]     = decide && slip_bad;
    set_vec[ddef_pkg::FRAME_CRC_FLAG]      = decide && crc_bad;
  end

  // an event in the clearing cycle survives: set wins over clear
  assign clr_vec = (decide && clear_write)
                   ? cap_frame[ddef_pkg::FLAG_W-1:0] : 10'h000;
  assign kept        = flags & ~clr_vec;
  assign next_flags  = (kept | set_vec) & ddef_pkg::FLAG_MASK;
  assign next_rb_sel = !(decide && accept) ? rb_sel
                     : !is_write ? addr
                     : addr == ddef_pkg::READBACK_SELECT_ADDR
                       ? cap_frame[ddef_pkg::ADDR_W-1:0] : rb_sel;

  always_ff @(posedge clock) begin
    if (srst) begin
      flags               <= ddef_pkg::FLAGS_RESET;
      digital_fault_flags <= ddef_pkg::FLAGS_RESET;
    end else if (ce) begin
      flags               <= next_flags;
      digital_fault_flags <= next_flags & digital_fault_enables;
    end
  end

  // snapshot taken per frame; the link shifts it out on the next frame
  always_ff @(posedge clock) begin
    if (srst) begin
      rb_sel  <= 5'h00;
      rb_word <= 24'h00_0000;
    end else if (ce && decide) begin
      rb_sel  <= next_rb_sel;
      rb_word <= {3'h0, next_rb_sel, 6'h00,
                  next_rb_sel == ddef_pkg::FAULT_FLAGS_ADDR
                  ? next_flags & digital_fault_enables : 10'h000};
    end
  end

  // ---------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  sequence decided_s;
    ce && decide;
  endsequence
  sequence clean_s;
    ce && decide && frame_ok;
  endsequence

  rc_parity_a: assert property (ce && rc_enable && rc_valid
    && ((^rc_word) != rc_parity) |=> flags[9])
    else $error("read-compare parity error not flagged");
  latch_mon_a: assert property (ce && latch_in != latch_out
    |=> flags[8] && $past(latch_in) != $past(latch_out))
    else $error("latch mismatch not flagged");
  inv_code_a: assert property (ce && dac_code != ~dac_code_inv
    |=> flags[6])
    else $error("inverted code mismatch not flagged");
  cal_crc_a: assert property (ce && ref_end
    && cal_bad |=> flags[5] && !cal_refresh_busy)
    else $error("calibration crc failure not flagged");
  bad_addr_a: assert property (clean_s
    ##0 !ddef_pkg::VALID_ADDR_MAP[addr] |=> flags[4])
    else $error("invalid address not flagged");
  early_write_a: assert property (clean_s ##0 is_write
    && !busy && !first_done |=> flags[4])
    else $error("write before first refresh not flagged");
  readback_ok_a: assert property (clean_s ##0 busy && is_write
    && addr == ddef_pkg::READBACK_SELECT_ADDR && !flags[4] |=> !flags[4])
    else $error("readback select during refresh flagged");
  ro_write_a: assert property (clean_s ##0 is_write
    && ddef_pkg::READ_ONLY_MAP[addr] |=> flags[4])
    else $error("read-only write not flagged");
  clk_count_a: assert property (decided_s ##0 (spi_crc_enable
    ? cap_cnt != 6'h20 : cap_cnt != 6'h20 && cap_cnt != 6'h18)
    |=> flags[2])
    else $error("edge count error not flagged");
  slip_a: assert property (decided_s ##0 cnt_ok
    && cap_frame[23] == cap_frame[22] |=> flags[1])
    else $error("slip error not flagged");
  spi_crc_a: assert property (ce && state == ddef_pkg::ST_START
    ##1 decided_s ##0 (spi_crc_enable && cnt_ok
    && spi_crc_bus.crc != cap_crc) |=> flags[0])
    else $error("frame crc error not flagged");
  sticky_a: assert property (ce |=> (flags & $past(kept))
    == $past(kept))
    else $error("flag dropped without a clearing write");
  enable_mask_a: assert property (ce |=> (digital_fault_flags
    & ~$past(digital_fault_enables)) == 10'h000)
    else $error("disabled flag reads nonzero");
  reserved_a: assert property ((flags & ~ddef_pkg::FLAG_MASK)
    == 10'h000 && digital_fault_flags[7] == 1'b0
    && digital_fault_flags[3] == 1'b0)
    else $error("reserved bit set");

endmodule // ddef_flags

// ---- src/ddef_pkg.sv ----
package ddef_pkg;

  // ---------------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------------
  localparam int FLAG_W  = 10;
  localparam int CRC_W   = 8;
  localparam int ADDR_W  = 5;
  localparam int FRAME_W = 24;
  localparam int SHIFT_W = 32;
  localparam int CNT_W   = 6;
  localparam int DATA_W  = 16;

  // ---------------------------------------------------------------------
  // flag positions in digital_fault_flags
  // ---------------------------------------------------------------------
  localparam int FRAME_CRC_FLAG                   = 0;
  localparam int FRAME_SLIP_FLAG                  = 1;
  localparam int CLOCK_COUNT_FLAG                 = 2;
  localparam int INVALID_ACCESS_FLAG              = 4;
  localparam int CAL_CRC_FLAG                     = 5;
  localparam int INVERTED_CODE_FLAG               = 6;
  localparam int LATCH_MONITOR_MISMATCH_FLAG      = 8;
  localparam int INTERDIE_READCOMPARE_PARITY_FLAG = 9;
  localparam logic [FLAG_W-1:0] FLAG_MASK   = 10'h377;
  localparam logic [FLAG_W-1:0] FLAGS_RESET = 10'h000;

  // ---------------------------------------------------------------------
  // frame layout and counts
  // ---------------------------------------------------------------------
  localparam int SLIP_MARK_POS = 23;
  localparam int SLIP_PAIR_POS = 22;
  localparam int WRITE_POS     = 21;
  localparam int ADDR_LSB      = 16;
  localparam logic [CNT_W-1:0] LONG_COUNT  = 6'h20;
  localparam logic [CNT_W-1:0] SHORT_COUNT = 6'h18;
  localparam logic [CNT_W-1:0] COUNT_MAX   = 6'h3f;

  // ---------------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] FAULT_FLAGS_ADDR     = 5'h14;
  localparam logic [ADDR_W-1:0] READBACK_SELECT_ADDR = 5'h13;
  localparam logic [31:0]       VALID_ADDR_MAP       = 32'h11ff_9fff;
  localparam logic [31:0]       READ_ONLY_MAP        = 32'h11c0_0000;

  // ---------------------------------------------------------------------
  // crc and timing
  // ---------------------------------------------------------------------
  localparam logic [CRC_W-1:0] CRC_POLY = 8'h07;
  localparam logic [CRC_W-1:0] CRC_INIT = 8'h00;
  localparam int CLOCK_MHZ      = 125;
  localparam int REFRESH_NS     = 1000;
  localparam int REFRESH_CYCLES = (REFRESH_NS * CLOCK_MHZ + 999) / 1000;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_START = 3'h2,
    ST_CHECK = 3'h4
  } ddef_state_type;

endpackage

// ---- src/ddef_crc_if.sv ----
`timescale 1ns/1ps
interface ddef_crc_if #(parameter int DW = 24);
  logic                        start;
  logic [DW-1:0]               data;
  logic [ddef_pkg::CRC_W-1:0]  crc;
  logic                        done;
  modport calc (input start, input data, output crc, output done);
  modport user (output start, output data, input crc, input done);
endinterface

// ---- src/ddef_crc.sv ----
`timescale 1ns/1ps
module ddef_crc #(
  parameter int DW = 24
) (
  input  wire logic     clock,
  input  wire logic     srst,
  input  wire logic     ce,
  ddef_crc_if.calc      port
);

  // ---------------------------------------------------------------------
  // crc-8, msb first over the whole word
  // ---------------------------------------------------------------------
  function automatic logic [ddef_pkg::CRC_W-1:0] crc_of(
    input logic [DW-1:0] d
  );
    logic [ddef_pkg::CRC_W-1:0] c;
    c = ddef_pkg::CRC_INIT;
    for (int i = DW - 1; i >= 0; i--) begin
      if (c[ddef_pkg::CRC_W-1] ^ d[i]) begin
        c = {c[ddef_pkg::CRC_W-2:0], 1'b0} ^ ddef_pkg::CRC_POLY;
      end else begin
        c = {c[ddef_pkg::CRC_W-2:0], 1'b0};
      end
    end
    return c;
  endfunction

  always_ff @(posedge clock) begin
    if (srst) begin
      port.crc  <= ddef_pkg::CRC_INIT;
      port.done <= 1'b0;
    end else if (ce) begin
      port.done <= port.start;
      if (port.start) begin
        port.crc <= crc_of(port.data);
      end
    end
  end

endmodule // ddef_crc

// ---- tb/ddef_host.sv ----
`timescale 1ns/1ps
// ---------------------------------------------------------------------
// serial host: sclk idles high and stands still between frames
// ---------------------------------------------------------------------
module ddef_host (
  output logic        spi_sclk,
  output logic        spi_cs_n,
  output logic        spi_mosi,
  input  wire logic   spi_miso
);
  logic [31:0] rx;
  initial begin
    spi_sclk = 1'b1;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
    rx = 32'h0;
  end
  // n falling edges, msb first; rx gathers miso at each rising edge
  task automatic frame(input logic [31:0] w, input int n);
    spi_cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      spi_mosi = w[i];
      #62.5 spi_sclk = 1'b0;
      #62.5 spi_sclk = 1'b1;
      rx = {rx[30:0], spi_miso};
    end
    #62.5 spi_cs_n = 1'b1;
    // released line: never leave the last bit showing
    spi_mosi = ~spi_mosi;
  endtask
endmodule // ddef_host

// ---- tb/digital_diag_error_flags_test.sv ----
`timescale 1ns/1ps
module digital_diag_error_flags_test;
  // ---------------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------------
  logic        clock, srst, ce, spi_sclk, spi_cs_n, spi_mosi, spi_miso;
  logic        spi_crc_enable, rc_enable, rc_valid, rc_parity;
  logic        cal_refresh_start, cal_refresh_busy, cal_unrefreshed;
  logic [9:0]  digital_fault_enables, digital_fault_flags;
  logic [15:0] rc_word, latch_in, latch_out, dac_code, dac_code_inv;
  logic [63:0] cal_contents;
  logic [7:0]  cal_stored_crc;
  int          n_errors, checks_done;

  ddef_host i_host (.spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso);
  // long refresh so a whole frame fits inside one
  ddef_flags #(.REFRESH_CYCLES(1000)) i_dut (
    .clock, .srst, .ce, .spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso,
    .spi_crc_enable, .digital_fault_enables, .rc_enable, .rc_valid,
    .rc_word, .rc_parity, .latch_in, .latch_out, .dac_code,
    .dac_code_inv, .cal_refresh_start, .cal_contents, .cal_stored_crc,
    .digital_fault_flags, .cal_refresh_busy, .cal_unrefreshed);

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // ---------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------
  function automatic logic [7:0] crc8(input logic [63:0] d, input int n);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 63; i > 63 - n; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic fl(input logic [9:0] e);
    chk({22'h0, digital_fault_flags}, {22'h0, e});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // frame spacing covers sync, check and flag update
  task automatic xfer(input logic w, input logic [4:0] a,
                      input logic [15:0] d);
    i_host.frame({8'h0, 2'b10, w, a, d}, 24);
    cyc(40);
  endtask
  task automatic cf(input logic [23:0] f, input logic [7:0] bad);
    i_host.frame({f, crc8({f, 40'h0}, 24) ^ bad}, 32);
    cyc(40);
  endtask
  task automatic clr;
    xfer(1'b1, 5'h14, 16'h03ff);
  endtask
  task automatic refresh(input logic [7:0] bad);
    cal_stored_crc = crc8(cal_contents, 64) ^ bad;
    cal_refresh_start = 1'b1;
    cyc(1);
    cal_refresh_start = 1'b0;
    cyc(1);
  endtask
  task automatic idle;
    for (int i = 0; i < 2000 && cal_refresh_busy !== 1'b0; i++)
      cyc(1);
  endtask

  // ---------------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------------
  initial begin
    #400_000;
    n_errors++;
    end_sim;
  end
  initial begin
    logic [5:0] acc [4];
    acc = '{6'h2d, 6'h19, 6'h36, 6'h1b};
    {srst, ce} = 2'b11;
    {spi_crc_enable, rc_enable, rc_valid, rc_parity} = 4'h0;
    {cal_refresh_start, rc_word, latch_in, latch_out, dac_code} = '0;
    dac_code_inv = 16'hffff;
    digital_fault_enables = 10'h3ff;
    cal_contents = 64'h0123_4567_89ab_cdef;
    cal_stored_crc = 8'h00;
    repeat (20) @(posedge clock);
    #1 srst = 1'b0;
    cyc(4);
    fl(10'h000);
    chk({31'h0, cal_unrefreshed}, 32'h1);
    xfer(1'b1, 5'h10, 16'h0000);
    fl(10'h010);
    refresh(8'h00);
    chk({31'h0, cal_refresh_busy}, 32'h1);
    idle;
    fl(10'h010);
    chk({31'h0, cal_unrefreshed}, 32'h0);
    clr;
    fl(10'h000);
    refresh(8'h5a);
    xfer(1'b1, 5'h13, 16'h0014);
    idle;
    fl(10'h020);
    refresh(8'h00);
    xfer(1'b1, 5'h10, 16'h0000);
    idle;
    fl(10'h030);
    clr;
    $display("refresh tests done");
    // bit 5 = write, low bits = address
    foreach (acc[i]) begin
      xfer(acc[i][5], acc[i][4:0], 16'h0000);
      fl(10'h010);
      xfer(1'b1, 5'h14, 16'h0000);
      fl(10'h010);
      clr;
      fl(10'h000);
    end
    $display("access tests done");
    i_host.frame({8'h0, 24'hd4_0000}, 24);
    cyc(40);
    fl(10'h002);
    clr;
    i_host.frame({8'h0, 24'h94_0000}, 23);
    cyc(40);
    fl(10'h004);
    clr;
    i_host.frame(32'h0, 0);
    cyc(40);
    fl(10'h004);
    clr;
    cf(24'h94_0000, 8'h00);
    fl(10'h000);
    spi_crc_enable = 1'b1;
    xfer(1'b0, 5'h14, 16'h0000);
    fl(10'h004);
    cf(24'hb4_03ff, 8'h00);
    fl(10'h000);
    cf(24'h94_0000, 8'h01);
    fl(10'h001);
    cf(24'hb4_03ff, 8'h00);
    spi_crc_enable = 1'b0;
    $display("frame tests done");
    latch_out = 16'h0001;
    cyc(1);
    latch_out = 16'h0000;
    cyc(3);
    fl(10'h100);
    dac_code_inv = 16'hfffe;
    cyc(1);
    dac_code_inv = 16'hffff;
    cyc(3);
    fl(10'h140);
    {rc_word, rc_valid} = {16'h0001, 1'b1};
    cyc(1);
    rc_valid = 1'b0;
    cyc(3);
    fl(10'h140);
    {rc_enable, rc_valid} = 2'b11;
    cyc(1);
    rc_valid = 1'b0;
    cyc(3);
    fl(10'h340);
    digital_fault_enables = 10'h000;
    cyc(3);
    fl(10'h000);
    digital_fault_enables = 10'h3ff;
    cyc(3);
    fl(10'h340);
    xfer(1'b0, 5'h14, 16'h0000);
    xfer(1'b0, 5'h14, 16'h0000);
    chk({8'h0, i_host.rx[23:0]}, 32'h0014_0340);
    clr;
    fl(10'h000);
    // clock enable low: a passing mismatch must leave no trace
    ce = 1'b0;
    latch_out = 16'h0001;
    cyc(2);
    {ce, latch_out} = {1'b1, 16'h0000};
    cyc(3);
    fl(10'h000);
    $display("core tests done");
    end_sim;
  end
endmodule // digital_diag_error_flags_test
